/* hdl/cprc_regs.svh */
// Register indices, field positions, reset values and timing constants
`ifndef CPRC_REGS_SVH
`define CPRC_REGS_SVH

// Register indices; byte address on the bus is four times the index
`define CPRC_IDX_PLL        10'h010
`define CPRC_IDX_RATIO      10'h1e0
`define CPRC_IDX_SRC        10'h1e1
`define CPRC_IDX_UPD        10'h232
`define CPRC_IDX_STAT       10'h233

// Field positions
`define CPRC_PD_MSB         1
`define CPRC_PD_LSB         0
`define CPRC_POL_BIT        7
`define CPRC_RATIO_MSB      2
`define CPRC_RATIO_LSB      0
`define CPRC_BYP_BIT        0
`define CPRC_SRC_BIT        1
`define CPRC_UPD_BIT        0

// Field codes
`define CPRC_PD_NORMAL      2'h0
`define CPRC_PD_ASYNC       2'h1
`define CPRC_UPD_CODE       8'h01

// Reset values
`define CPRC_RST_PLL        8'h01
`define CPRC_RST_RATIO_REG  8'h02
`define CPRC_RST_RATIO      3'h2
`define CPRC_RST_SRC        8'h00

// Pre-divider limits and distribution ceiling
`define CPRC_DIV_MIN        3'h2
`define CPRC_DIV_MAX        3'h6
`define CPRC_RATIO_TOP      3'h4
`define CPRC_DIST_MAX_MHZ   1600
`define CPRC_MCLK_MHZ       125

`endif

/* hdl/cprc_pkg.sv */
// Types and shared decode for the clock path route configuration block
`default_nettype none

package cprc_pkg;

    typedef logic [7:0] cprc_byte_t;

    // Active routing configuration
    typedef struct packed {
        logic [1:0] pd;
        logic       pol;
        logic [2:0] ratio;
        logic       byp;
        logic       src;
    } cprc_cfg_s;

    // Core state
    typedef struct packed {
        cprc_byte_t stg_pll;
        cprc_byte_t stg_ratio;
        cprc_byte_t stg_src;
        logic       upd;
        cprc_cfg_s  act;
        logic       pll_on;
        logic       vco_pwr;
        logic       ext_pre;
        logic [2:0] div_val;
        logic [2:0] cnt;
        logic       dist_en;
        cprc_byte_t rdat;
    } cprc_core_s;

    // Bus slave state
    typedef struct packed {
        logic ack;
    } cprc_slv_s;

    // Ratio code to division factor; codes past the top fall to the
    // largest ratio so a stray code can only slow the distribution clock
    function automatic logic [2:0] cprc_ratio_div(input logic [2:0] code);
        logic [2:0] r;
        r = 3'h6;
        if (code <= 3'h4) begin
            r = code + 3'h2;
        end
        return r;
    endfunction

endpackage

`default_nettype wire

/* hdl/cprc_reg_if.sv */
// Register access carrier between the bus slave and the core
`default_nettype none

interface cprc_reg_if;
    logic       req;
    logic       wr;
    logic [9:0] idx;
    logic [7:0] wdat;

    modport bus  (output req, output wr, output idx, output wdat);
    modport core (input req, input wr, input idx, input wdat);
endinterface

`default_nettype wire

/* hdl/cprc_wb_slave.sv */
// Classic Wishbone slave front end with a one-cycle registered ack
`default_nettype none

module cprc_wb_slave (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Wishbone request
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic        we,
    input  wire logic [3:0]  sel,
    input  wire logic [11:0] adr,
    input  wire logic [31:0] dat_i,
    // Wishbone answer
    output logic             ack,
    // Core side
    cprc_reg_if.bus          rif
);

    cprc_pkg::cprc_slv_s q;
    cprc_pkg::cprc_slv_s d;

    // Request taken once; ack blocks a second take of the held request
    assign rif.req  = cyc & stb & ~q.ack;
    // Registers are eight bits wide, so only lane 0 can write
    assign rif.wr   = rif.req & we & sel[0];
    assign rif.idx  = adr[11:2];
    assign rif.wdat = dat_i[7:0];
    assign ack      = q.ack;

    always_comb begin
        d     = q;
        d.ack = rif.req;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    chk_ack_one_cycle :
    assert property (@(posedge mclk) disable iff (rst) ack |=> !ack)
        else $error("ack held longer than one cycle");

    chk_ack_follows_req :
    assert property (@(posedge mclk) disable iff (rst)
        (cyc && stb && !ack) |=> ack)
        else $error("request not answered in the next cycle");

endmodule

`default_nettype wire

/* hdl/cprc_top.sv */
// Clock path routing configuration: staged registers, update, pre-divider
//
// Functional notes
// - Reset loads PLL power field with asynchronous power-down code 01b.
// - PLL power code 00b means PLL powered and running normally.
// - Pre-divider ratio field resets to 010b, division by four.
// - Bypass bit 0 (reset) routes the source through the pre-divider.
// - Source-select 0 (reset) picks the external clock input, not VCO.
// - Staged values become active only after writing 0x01 to update.
// - PFD polarity bit: 0 positive, 1 negative.
// - Distribution clock at most 1600 MHz; pre-divider minimum ratio two.
// - Pre-divider supports ratios two through six from a 3-bit field.
// - PLL on with external input keeps VCO off, feeds prescaler.
//
// Local design decision: register access over Wishbone.
`include "cprc_regs.svh"
`default_nettype none

module cprc_top (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // PLL controls
    output logic [1:0]       pll_pd_mode_o,
    output logic             pll_on_o,
    output logic             pfd_pol_neg_o,
    output logic             vco_pwr_en_o,
    output logic             ext_to_prescaler_o,
    // Distribution routing
    output logic [2:0]       prediv_div_o,
    output logic             prediv_bypass_o,
    output logic             src_vco_o,
    output logic             dist_clk_en_o
);

    cprc_reg_if rif ();

    cprc_pkg::cprc_core_s q;
    cprc_pkg::cprc_core_s d;

    cprc_wb_slave u_slave (
        .mclk  (mclk),
        .rst   (rst),
        .cyc   (wb_cyc_i),
        .stb   (wb_stb_i),
        .we    (wb_we_i),
        .sel   (wb_sel_i),
        .adr   (wb_adr_i),
        .dat_i (wb_dat_i),
        .ack   (wb_ack_o),
        .rif   (rif)
    );

    logic       upd_wr;
    logic [2:0] cur_div;

    assign upd_wr = rif.wr && (rif.idx == `CPRC_IDX_UPD)
                    && (rif.wdat == `CPRC_UPD_CODE);
    assign cur_div = cprc_pkg::cprc_ratio_div(q.act.ratio);

    always_comb begin
        d = q;

        // Host writes only reach the staging copies
        if (rif.wr) begin
            unique case (rif.idx)
                `CPRC_IDX_PLL:   d.stg_pll   = rif.wdat;
                `CPRC_IDX_RATIO: d.stg_ratio = rif.wdat;
                `CPRC_IDX_SRC:   d.stg_src   = rif.wdat;
                default:         d.stg_pll   = d.stg_pll;
            endcase
        end

        // Copy staging into the active set, then drop the trigger
        if (q.upd) begin
            d.act.pd    = q.stg_pll[`CPRC_PD_MSB:`CPRC_PD_LSB];
            d.act.pol   = q.stg_pll[`CPRC_POL_BIT];
            d.act.ratio = q.stg_ratio[`CPRC_RATIO_MSB:`CPRC_RATIO_LSB];
            d.act.byp   = q.stg_src[`CPRC_BYP_BIT];
            d.act.src   = q.stg_src[`CPRC_SRC_BIT];
            d.upd       = 1'b0;
        end
        // A new trigger landing with the self-clear wins
        if (upd_wr) begin
            d.upd = 1'b1;
        end

        // Derived controls follow the active set in the same cycle
        d.pll_on  = (d.act.pd == `CPRC_PD_NORMAL);
        // Internal VCO only runs when PLL is on and VCO is the source
        d.vco_pwr = d.pll_on && d.act.src;
        d.ext_pre = d.pll_on && !d.act.src;
        d.div_val = cprc_pkg::cprc_ratio_div(d.act.ratio);

        // Pre-divider: one enable pulse per division period
        if (q.act.byp) begin
            d.cnt     = 3'h0;
            d.dist_en = 1'b1;
        end else if (q.cnt >= cur_div - 3'h1) begin
            d.cnt     = 3'h0;
            d.dist_en = 1'b1;
        end else begin
            d.cnt     = q.cnt + 3'h1;
            d.dist_en = 1'b0;
        end

        // Read data captured with the take; unmapped reads give zero
        if (rif.req) begin
            unique case (rif.idx)
                `CPRC_IDX_PLL:   d.rdat = q.stg_pll;
                `CPRC_IDX_RATIO: d.rdat = q.stg_ratio;
                `CPRC_IDX_SRC:   d.rdat = q.stg_src;
                `CPRC_IDX_UPD:   d.rdat = {7'h00, q.upd};
                `CPRC_IDX_STAT:  d.rdat = {q.act.src, q.act.byp,
                                           q.act.ratio, q.act.pol,
                                           q.act.pd};
                default:         d.rdat = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q           <= '0;
            q.stg_pll   <= `CPRC_RST_PLL;
            q.stg_ratio <= `CPRC_RST_RATIO_REG;
            q.stg_src   <= `CPRC_RST_SRC;
            q.act.pd    <= `CPRC_PD_ASYNC;
            q.act.ratio <= `CPRC_RST_RATIO;
            q.div_val   <= cprc_pkg::cprc_ratio_div(`CPRC_RST_RATIO);
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o           = {24'h000000, q.rdat};
    assign pll_pd_mode_o      = q.act.pd;
    assign pll_on_o           = q.pll_on;
    assign pfd_pol_neg_o      = q.act.pol;
    assign vco_pwr_en_o       = q.vco_pwr;
    assign ext_to_prescaler_o = q.ext_pre;
    assign prediv_div_o       = q.div_val;
    assign prediv_bypass_o    = q.act.byp;
    assign src_vco_o          = q.act.src;
    assign dist_clk_en_o      = q.dist_en;

    // Helper: cycles since the last enable pulse, and whether the ratio
    // stayed put over that gap; a mid-count ratio change gives one odd gap
    logic [3:0] gap_cnt;
    logic [2:0] div_seen;
    logic       gap_clean;
    always_ff @(posedge mclk) begin
        div_seen <= prediv_div_o;
        if (rst) begin
            gap_cnt   <= 4'h0;
            gap_clean <= 1'b1;
        end else if (dist_clk_en_o) begin
            gap_cnt   <= 4'h1;
            gap_clean <= 1'b1;
        end else begin
            if (gap_cnt != 4'hf) begin
                gap_cnt <= gap_cnt + 4'h1;
            end
            if (prediv_div_o != div_seen) begin
                gap_clean <= 1'b0;
            end
        end
    end

    chk_reset_pll_off :
    assert property (@(posedge mclk)
        $fell(rst) |-> pll_pd_mode_o == `CPRC_PD_ASYNC && !pll_on_o)
        else $error("PLL not powered down after reset");

    chk_pll_normal_on :
    assert property (@(posedge mclk) disable iff (rst)
        pll_on_o == (pll_pd_mode_o == `CPRC_PD_NORMAL))
        else $error("PLL run state disagrees with power code");

    chk_reset_div_four :
    assert property (@(posedge mclk)
        $fell(rst) |-> prediv_div_o == 3'h4 && !prediv_bypass_o
                       && !src_vco_o)
        else $error("reset routing is not external through divide by four");

    chk_divider_period :
    assert property (@(posedge mclk) disable iff (rst)
        dist_clk_en_o && !prediv_bypass_o && $stable(prediv_div_o)
        && $past(dist_clk_en_o) == 1'b0 && gap_clean
        |-> gap_cnt == {1'b0, prediv_div_o})
        else $error("pre-divider pulse spacing wrong");

    chk_bypass_every :
    assert property (@(posedge mclk) disable iff (rst)
        prediv_bypass_o && $past(prediv_bypass_o) |-> dist_clk_en_o)
        else $error("bypass path missing enable");

    chk_hold_until_upd :
    assert property (@(posedge mclk) disable iff (rst)
        !q.upd |=> $stable(q.act))
        else $error("active settings changed without update");

    chk_upd_transfer :
    assert property (@(posedge mclk) disable iff (rst)
        q.upd |=> prediv_div_o == cprc_pkg::cprc_ratio_div(
                      $past(q.stg_ratio[2:0]))
                  && src_vco_o == $past(q.stg_src[1]))
        else $error("staged values not transferred");

    chk_pol_transfer :
    assert property (@(posedge mclk) disable iff (rst)
        q.upd |=> pfd_pol_neg_o == $past(q.stg_pll[7]))
        else $error("polarity not taken from staging");

    chk_min_div_two :
    assert property (@(posedge mclk) disable iff (rst)
        !prediv_bypass_o && $past(!prediv_bypass_o) && dist_clk_en_o
        |=> !dist_clk_en_o)
        else $error("pre-divider ran faster than divide by two");

    chk_div_range :
    assert property (@(posedge mclk) disable iff (rst)
        prediv_div_o >= `CPRC_DIV_MIN && prediv_div_o <= `CPRC_DIV_MAX)
        else $error("division ratio out of range");

    chk_vco_off_ext :
    assert property (@(posedge mclk) disable iff (rst)
        pll_on_o && !src_vco_o |-> !vco_pwr_en_o && ext_to_prescaler_o)
        else $error("VCO powered while external source feeds PLL");

    chk_upd_selfclear :
    assert property (@(posedge mclk) disable iff (rst)
        q.upd && !upd_wr |=> !q.upd)
        else $error("update bit did not clear");

    chk_upd_set_wins :
    assert property (@(posedge mclk) disable iff (rst)
        upd_wr |=> q.upd)
        else $error("update trigger lost");

    chk_reset_pll_stage :
    assert property (@(posedge mclk)
        $fell(rst) |-> q.stg_pll == `CPRC_RST_PLL)
        else $error("PLL staging not at its default after reset");

    chk_reset_ratio_stage :
    assert property (@(posedge mclk)
        $fell(rst) |-> q.stg_ratio == `CPRC_RST_RATIO_REG && !q.upd)
        else $error("ratio staging or update bit wrong after reset");

    chk_reset_src_stage :
    assert property (@(posedge mclk)
        $fell(rst) |-> q.stg_src == `CPRC_RST_SRC)
        else $error("source staging not at its default after reset");

    chk_reset_quiet :
    assert property (@(posedge mclk)
        $fell(rst) |-> !dist_clk_en_o && !wb_ack_o)
        else $error("enable or ack active right after reset");

    chk_ext_no_vco :
    assert property (@(posedge mclk) disable iff (rst)
        !src_vco_o |-> !vco_pwr_en_o)
        else $error("VCO powered while external input is the source");

    chk_ext_pre_cond :
    assert property (@(posedge mclk) disable iff (rst)
        ext_to_prescaler_o |-> pll_on_o && !src_vco_o)
        else $error("prescaler fed from external input wrongly");

    chk_pll_off_codes :
    assert property (@(posedge mclk) disable iff (rst)
        pll_pd_mode_o != `CPRC_PD_NORMAL
        |-> !pll_on_o && !vco_pwr_en_o && !ext_to_prescaler_o)
        else $error("PLL side active under a power-down code");

    chk_pd_transfer :
    assert property (@(posedge mclk) disable iff (rst)
        q.upd |=> pll_pd_mode_o == $past(q.stg_pll[1:0]))
        else $error("power code not taken from staging");

    chk_byp_transfer :
    assert property (@(posedge mclk) disable iff (rst)
        q.upd |=> prediv_bypass_o == $past(q.stg_src[0]))
        else $error("bypass bit not taken from staging");

    chk_div_hold :
    assert property (@(posedge mclk) disable iff (rst)
        !q.upd |=> $stable(prediv_div_o) && $stable(pll_pd_mode_o))
        else $error("routing changed without update");

    chk_pol_hold :
    assert property (@(posedge mclk) disable iff (rst)
        !q.upd |=> $stable(pfd_pol_neg_o))
        else $error("polarity changed without update");

    chk_stage_pll_write :
    assert property (@(posedge mclk) disable iff (rst)
        rif.wr && rif.idx == `CPRC_IDX_PLL
        |=> q.stg_pll == $past(rif.wdat))
        else $error("PLL staging write lost");

    chk_stage_ratio_write :
    assert property (@(posedge mclk) disable iff (rst)
        rif.wr && rif.idx == `CPRC_IDX_RATIO
        |=> q.stg_ratio == $past(rif.wdat))
        else $error("ratio staging write lost");

    chk_stage_src_write :
    assert property (@(posedge mclk) disable iff (rst)
        rif.wr && rif.idx == `CPRC_IDX_SRC
        |=> q.stg_src == $past(rif.wdat))
        else $error("source staging write lost");

    chk_upd_only_code :
    assert property (@(posedge mclk) disable iff (rst)
        !q.upd && !upd_wr |=> !q.upd)
        else $error("update bit set without the trigger code");

    chk_upd_readback :
    assert property (@(posedge mclk) disable iff (rst)
        rif.req && rif.idx == `CPRC_IDX_UPD
        |=> wb_dat_o == {31'h00000000, $past(q.upd)})
        else $error("update bit read back wrong");

endmodule

`default_nettype wire

/* bench/test_clock_path_route_config.sv */
// Self-checking bench for the clock path route configuration block
`include "cprc_regs.svh"
`default_nettype none

module test_clock_path_route_config;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] a_pll  = {`CPRC_IDX_PLL, 2'h0};
    localparam logic [11:0] a_rat  = {`CPRC_IDX_RATIO, 2'h0};
    localparam logic [11:0] a_src  = {`CPRC_IDX_SRC, 2'h0};
    localparam logic [11:0] a_upd  = {`CPRC_IDX_UPD, 2'h0};
    localparam logic [11:0] a_stat = {`CPRC_IDX_STAT, 2'h0};

    logic        mclk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [1:0]  pd_mode;
    logic        pll_on;
    logic        pol_neg;
    logic        vco_en;
    logic        ext_pre;
    logic [2:0]  div;
    logic        byp;
    logic        src_vco;
    logic        dist_en;
    logic [31:0] q;
    logic [31:0] rnd;
    logic [7:0]  p;
    logic [7:0]  r;
    logic [7:0]  s;
    int          num_errors;
    int          cmp_count;

    cprc_top dut (
        .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_ack_o(ack), .wb_dat_o(rdat), .pll_pd_mode_o(pd_mode),
        .pll_on_o(pll_on), .pfd_pol_neg_o(pol_neg), .vco_pwr_en_o(vco_en),
        .ext_to_prescaler_o(ext_pre), .prediv_div_o(div),
        .prediv_bypass_o(byp), .src_vco_o(src_vco), .dist_clk_en_o(dist_en)
    );

    always #4 mclk = ~mclk;

    function automatic logic [2:0] exp_div(input logic [2:0] c);
        return (c <= 3'h4) ? c + 3'h2 : 3'h6;
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Entered just after a rising edge; ack and read data are taken at
    // the rising edge where ack is sampled high, before the slave updates
    task automatic wb(input logic w, input logic [3:0] b,
                      input logic [11:0] a, input logic [7:0] d);
        int n;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= b;
        adr  <= a;
        wdat <= {rnd[31:8], d};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic expect_cfg(input logic [7:0] pp, rr, ss);
        logic on;
        int   n;
        int   per;
        on = (pp[1:0] == 2'h0);
        @(negedge mclk);
        chk(pd_mode, pp[1:0]);
        chk(pll_on, on);
        chk(pol_neg, pp[7]);
        chk(vco_en, on & ss[1]);
        chk(ext_pre, on & ~ss[1]);
        chk(div, exp_div(rr[2:0]));
        chk(byp, ss[0]);
        chk(src_vco, ss[1]);
        n = 0;
        while (dist_en !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        per = 0;
        do begin
            @(negedge mclk);
            per++;
        end while (dist_en !== 1'b1 && per < 20);
        chk(per, ss[0] ? 1 : exp_div(rr[2:0]));
        @(posedge mclk);
    endtask

    task automatic check_defaults;
        wb(1'b0, 4'h1, a_pll, 8'h00);
        chk(q, 32'h01);
        wb(1'b0, 4'h1, a_rat, 8'h00);
        chk(q, 32'h02);
        wb(1'b0, 4'h1, a_src, 8'h00);
        chk(q, 32'h00);
        wb(1'b0, 4'h1, a_upd, 8'h00);
        chk(q, 32'h00);
        expect_cfg(8'h01, 8'h02, 8'h00);
    endtask

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        sel = 4'h0;
        adr = 12'h000;
        wdat = 32'h0;
        rnd = 32'h44ee0840;
        num_errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        check_defaults();
        // Staged values and a wrong trigger code must not reach the outputs
        wb(1'b1, 4'h1, a_pll, 8'h80);
        wb(1'b1, 4'h1, a_rat, 8'h00);
        wb(1'b1, 4'h1, a_src, 8'h03);
        expect_cfg(8'h01, 8'h02, 8'h00);
        wb(1'b1, 4'h1, a_upd, 8'h02);
        expect_cfg(8'h01, 8'h02, 8'h00);
        wb(1'b1, 4'he, a_rat, 8'h04);
        wb(1'b1, 4'h1, a_upd, 8'h01);
        wb(1'b0, 4'h1, a_upd, 8'h00);
        chk(q, 32'h0);
        expect_cfg(8'h80, 8'h00, 8'h03);
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(lfsr(lfsr(rnd)));
            p = rnd[7:0];
            r = (i < 8) ? {rnd[15:11], 3'(i)} : rnd[15:8];
            s = rnd[23:16];
            wb(1'b1, 4'h1, a_pll, p);
            wb(1'b1, 4'h1, a_rat, r);
            wb(1'b1, 4'h1, a_src, s);
            wb(1'b0, 4'h1, a_pll, 8'h00);
            chk(q, {24'h0, p});
            wb(1'b0, 4'h1, a_rat, 8'h00);
            chk(q, {24'h0, r});
            wb(1'b0, 4'h1, a_src, 8'h00);
            chk(q, {24'h0, s});
            wb(1'b1, 4'h1, a_upd, 8'h01);
            wb(1'b0, 4'h1, a_upd, 8'h00);
            chk(q, 32'h0);
            wb(1'b0, 4'h1, a_stat, 8'h00);
            chk(q, {24'h0, s[1:0], r[2:0], p[7], p[1:0]});
            expect_cfg(p, r, s);
        end
        // Unmapped place: write dropped, read gives zero
        wb(1'b1, 4'h1, 12'h100, 8'hff);
        wb(1'b0, 4'h1, 12'h100, 8'h00);
        chk(q, 32'h0);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        check_defaults();
        summarize();
    end

    // Whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        summarize();
    end
endmodule

`default_nettype wire
